//--- design/cpes_pkg.sv
// shared constants for the power and error status block
package cpes_pkg;

    // function counts and field widths
    localparam int unsigned NUM_PF     = 2;
    localparam int unsigned NUM_VF     = 6;
    localparam int unsigned PWR_W      = 3;
    localparam int unsigned LINK_W     = 2;
    localparam int unsigned VF_STAT_W  = 2 * NUM_VF;
    localparam int unsigned PF_PWR_W   = PWR_W * NUM_PF;
    localparam int unsigned VF_PWR_W   = PWR_W * NUM_VF;

    // register byte offsets (low address bits only)
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_VF_STAT  = 8'h04;
    localparam logic [7:0] OFS_PF_PWR   = 8'h08;
    localparam logic [7:0] OFS_VF_PWR   = 8'h0c;
    localparam logic [7:0] OFS_LINK_PWR = 8'h10;
    localparam logic [7:0] OFS_DEV_STAT = 8'h14;

    // control register fields
    localparam int unsigned CTRL_ROOT_BIT = 0;
    localparam int unsigned CTRL_EN_LSB   = 1;

    // function power state codes
    localparam logic [2:0] PWR_D0_UNINIT = 3'h0;
    localparam logic [2:0] PWR_D0_ACTIVE = 3'h1;
    localparam logic [2:0] PWR_D1        = 3'h2;
    localparam logic [2:0] PWR_D3_HOT    = 3'h4;

    // link power state codes
    localparam logic [1:0] LINK_L0  = 2'h0;
    localparam logic [1:0] LINK_L0S = 2'h1;
    localparam logic [1:0] LINK_L1  = 2'h2;
    localparam logic [1:0] LINK_L2  = 2'h3;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    // reset values
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

endpackage

//--- design/cpes_status_outputs.sv
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module cpes_status_outputs #(
    parameter int unsigned NUM_PF = cpes_pkg::NUM_PF,
    parameter int unsigned NUM_VF = cpes_pkg::NUM_VF
) (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    input  wire logic [NUM_PF-1:0]       cor_err_detect,
    input  wire logic                    cor_err_local,
    input  wire logic                    cor_err_remote_msg,
    output logic                         remote_err_msg_out,
    output logic [2*NUM_VF-1:0]          virtual_fn_enable_status,
    output logic [3*NUM_PF-1:0]          function_power_state,
    output logic [3*NUM_VF-1:0]          virtual_fn_power_state,
    output logic [1:0]                   link_power_state,
    output logic                         cor_err_out
);

    // local widths derived from the function counts
    localparam int unsigned PW     = cpes_pkg::PWR_W;
    localparam int unsigned VSW    = 2 * NUM_VF;
    localparam int unsigned PPW    = PW * NUM_PF;
    localparam int unsigned VPW    = PW * NUM_VF;
    localparam int unsigned CTRL_W = 1 + NUM_PF;

    // register map, one word each, upper bits read zero:
    //   0x00 control: bit0 root port mode, bits[2:1] correctable report enables
    //   0x04 vf enable and bus master pairs
    //   0x08 pf power fields, 0x0c vf power fields
    //   0x10 link power state
    //   0x14 correctable status per pf, write one to clear
    //   other offsets read zero and ignore writes
    // bit1 of control also gates root-port local errors, so a root port
    // with reporting off stays silent on the correctable output

    // address phase capture for the following data phase
    logic                 wr_pend_ff;
    logic [7:0]           wr_addr_ff;
    logic                 rd_hit;
    logic                 wr_hit;
    logic [31:0]          nxt_rdata;

    // software-visible state
    logic [CTRL_W-1:0]    ctrl_ff;
    logic [VSW-1:0]       vf_stat_ff;
    logic [PPW-1:0]       pf_pwr_ff;
    logic [VPW-1:0]       vf_pwr_ff;
    logic [1:0]           link_pwr_ff;
    logic [NUM_PF-1:0]    dev_stat_ff;

    // output flops
    logic                 hreadyout_ff;
    logic [31:0]          hrdata_ff;
    logic [VSW-1:0]       vf_stat_out_ff;
    logic [PPW-1:0]       pf_pwr_out_ff;
    logic [VPW-1:0]       vf_pwr_out_ff;
    logic [1:0]           link_pwr_out_ff;
    logic                 cor_err_ff;
    logic                 remote_msg_ff;
    logic                 hresp_ff;

    // decoded control and next-state terms
    logic                 root_mode;
    logic [NUM_PF-1:0]    report_en;
    logic [PPW-1:0]       nxt_pf_pwr;
    logic [VPW-1:0]       nxt_vf_pwr;
    logic [NUM_PF-1:0]    nxt_dev_stat;
    logic                 nxt_cor_err;
    logic                 wr_data_phase;

    // control decode; a write phase follows every accepted write address
    assign root_mode     = ctrl_ff[cpes_pkg::CTRL_ROOT_BIT];
    assign report_en     = ctrl_ff[CTRL_W-1:cpes_pkg::CTRL_EN_LSB];
    assign wr_data_phase = wr_pend_ff;

    // only a real transfer with hready high starts an access
    // hsize is not checked: every register is a whole word
    assign rd_hit = hsel && hready && (htrans == cpes_pkg::HTRANS_NONSEQ) && !hwrite;
    assign wr_hit = hsel && hready && (htrans == cpes_pkg::HTRANS_NONSEQ) && hwrite;

    // slave never stalls, so every transfer ends in one data phase;
    // low in reset so no transfer is taken before the block is alive
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
        end
    end

    // response is always okay, still launched from a flop like the rest
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_ff <= cpes_pkg::HRESP_OKAY;
        end else begin
            hresp_ff <= cpes_pkg::HRESP_OKAY;
        end
    end

    // a write is applied in its data phase, when hwdata is valid
    // only haddr[7:0] is decoded, so the map repeats every 256 bytes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= wr_hit;
            if (wr_hit) begin
                wr_addr_ff <= haddr[7:0];
            end
        end
    end

    // read mux; unmapped offsets read as zero
    // a read pipelined behind a write to the same word shows the old value
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (haddr[7:0])
            cpes_pkg::OFS_CTRL:     nxt_rdata[CTRL_W-1:0] = ctrl_ff;
            cpes_pkg::OFS_VF_STAT:  nxt_rdata[VSW-1:0]    = vf_stat_ff;
            cpes_pkg::OFS_PF_PWR:   nxt_rdata[PPW-1:0]    = pf_pwr_ff;
            cpes_pkg::OFS_VF_PWR:   nxt_rdata[VPW-1:0]    = vf_pwr_ff;
            cpes_pkg::OFS_LINK_PWR: nxt_rdata[1:0]        = link_pwr_ff;
            cpes_pkg::OFS_DEV_STAT: nxt_rdata[NUM_PF-1:0] = dev_stat_ff;
            default:                nxt_rdata = 32'h0000_0000;
        endcase
    end

    // read data is sampled at the address phase edge, stands in data phase
    // held until the next read, so a slow master still sees it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= cpes_pkg::RST_ZERO;
        end else if (rd_hit) begin
            hrdata_ff <= nxt_rdata;
        end
    end

    // control: root port mode and per-function report enables
    // report enables double as the per-function correctable mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= cpes_pkg::RST_CTRL[CTRL_W-1:0];
        end else if (wr_data_phase && wr_addr_ff == cpes_pkg::OFS_CTRL) begin
            ctrl_ff <= hwdata[CTRL_W-1:0];
        end
    end

    // vf enable and bus master bits, pairs per function
    // every pattern is legal, so no write filter here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vf_stat_ff <= cpes_pkg::RST_ZERO[VSW-1:0];
        end else if (wr_data_phase && wr_addr_ff == cpes_pkg::OFS_VF_STAT) begin
            vf_stat_ff <= hwdata[VSW-1:0];
        end
    end

    // is a three-bit code one of the four defined states
    // the other four codes have no meaning and are refused
    function automatic logic pwr_code_ok(input logic [2:0] code);
        pwr_code_ok = (code == cpes_pkg::PWR_D0_UNINIT) ||
                      (code == cpes_pkg::PWR_D0_ACTIVE) ||
                      (code == cpes_pkg::PWR_D1) ||
                      (code == cpes_pkg::PWR_D3_HOT);
    endfunction

    // per-field write filter: an undefined code leaves that field untouched
    // other fields of the same write still update
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PF; gp++) begin : g_pf_fld
            always_comb begin
                nxt_pf_pwr[gp*PW +: PW] = pf_pwr_ff[gp*PW +: PW];
                if (wr_data_phase && wr_addr_ff == cpes_pkg::OFS_PF_PWR &&
                    pwr_code_ok(hwdata[gp*PW +: PW])) begin
                    nxt_pf_pwr[gp*PW +: PW] = hwdata[gp*PW +: PW];
                end
            end
        end
        for (gp = 0; gp < NUM_VF; gp++) begin : g_vf_fld
            always_comb begin
                nxt_vf_pwr[gp*PW +: PW] = vf_pwr_ff[gp*PW +: PW];
                if (wr_data_phase && wr_addr_ff == cpes_pkg::OFS_VF_PWR &&
                    pwr_code_ok(hwdata[gp*PW +: PW])) begin
                    nxt_vf_pwr[gp*PW +: PW] = hwdata[gp*PW +: PW];
                end
            end
        end
    endgenerate

    // stored power states
    // the per-field loops above already dropped undefined codes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pf_pwr_ff <= cpes_pkg::RST_ZERO[PPW-1:0];
            vf_pwr_ff <= cpes_pkg::RST_ZERO[VPW-1:0];
        end else begin
            pf_pwr_ff <= nxt_pf_pwr;
            vf_pwr_ff <= nxt_vf_pwr;
        end
    end

    // link state: all four codes are legal, 11 covers l2 and reserved
    // written straight through; no code needs refusing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_pwr_ff <= cpes_pkg::LINK_L0;
        end else if (wr_data_phase && wr_addr_ff == cpes_pkg::OFS_LINK_PWR) begin
            link_pwr_ff <= hwdata[1:0];
        end
    end

    // device status correctable bits: set by detection, write one to clear;
    // a detection in the clearing cycle wins so no error is lost
    always_comb begin
        nxt_dev_stat = dev_stat_ff;
        if (wr_data_phase && wr_addr_ff == cpes_pkg::OFS_DEV_STAT) begin
            nxt_dev_stat = dev_stat_ff & ~hwdata[NUM_PF-1:0];
        end
        nxt_dev_stat = nxt_dev_stat | cor_err_detect;
    end

    // correctable status flops, set regardless of the report enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dev_stat_ff <= cpes_pkg::RST_ZERO[NUM_PF-1:0];
        end else begin
            dev_stat_ff <= nxt_dev_stat;
        end
    end

    // correctable error event; remote message reports are kept out on purpose
    // the report enables are the mask; in root mode function detections
    // are not local errors and stay out of the output
    always_comb begin
        if (root_mode) begin
            nxt_cor_err = cor_err_local && report_en[0];
        end else begin
            nxt_cor_err = |(cor_err_detect & report_en);
        end
    end

    // one-cycle pulse per detection cycle; back-to-back errors give a level
    // no stretching, so a tally of high cycles counts detection cycles exactly
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cor_err_ff <= 1'b0;
        end else begin
            cor_err_ff <= nxt_cor_err;
        end
    end

    // remote reports go only to the message side path
    // same one-cycle latency as the correctable path
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remote_msg_ff <= 1'b0;
        end else begin
            remote_msg_ff <= cor_err_remote_msg;
        end
    end

    // vf status output, one cycle behind the stored state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vf_stat_out_ff <= cpes_pkg::RST_ZERO[VSW-1:0];
        end else begin
            vf_stat_out_ff <= vf_stat_ff;
        end
    end

    // link state output, l0 while in reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_pwr_out_ff <= cpes_pkg::LINK_L0;
        end else begin
            link_pwr_out_ff <= link_pwr_ff;
        end
    end

    // root port hides stored pf and vf power states and reports d0 uninitialised on both power outputs;
    // stored values stay readable and come back when root mode is left
    genvar go;
    generate
        for (go = 0; go < NUM_PF; go++) begin : g_pf_out
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pf_pwr_out_ff[go*PW +: PW] <= cpes_pkg::PWR_D0_UNINIT;
                end else if (root_mode) begin
                    pf_pwr_out_ff[go*PW +: PW] <= cpes_pkg::PWR_D0_UNINIT;
                end else begin
                    pf_pwr_out_ff[go*PW +: PW] <= pf_pwr_ff[go*PW +: PW];
                end
            end
        end
        for (go = 0; go < NUM_VF; go++) begin : g_vf_out
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    vf_pwr_out_ff[go*PW +: PW] <= cpes_pkg::PWR_D0_UNINIT;
                end else if (root_mode) begin
                    vf_pwr_out_ff[go*PW +: PW] <= cpes_pkg::PWR_D0_UNINIT;
                end else begin
                    vf_pwr_out_ff[go*PW +: PW] <= vf_pwr_ff[go*PW +: PW];
                end
            end
        end
    endgenerate

    // every output is a straight copy of a flop
    assign hreadyout                = hreadyout_ff;
    assign hresp                    = hresp_ff;
    assign hrdata                   = hrdata_ff;
    assign remote_err_msg_out       = remote_msg_ff;
    assign virtual_fn_enable_status = vf_stat_out_ff;
    assign function_power_state     = pf_pwr_out_ff;
    assign virtual_fn_power_state   = vf_pwr_out_ff;
    assign link_power_state         = link_pwr_out_ff;
    assign cor_err_out              = cor_err_ff;

endmodule

`default_nettype wire

//--- test/cpes_status_outputs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module cpes_status_outputs_checker #(
    parameter int unsigned NUM_PF = cpes_pkg::NUM_PF,
    parameter int unsigned NUM_VF = cpes_pkg::NUM_VF
) (
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic                hready,
    input wire logic                hreadyout,
    input wire logic [NUM_PF-1:0]   cor_err_detect,
    input wire logic                cor_err_local,
    input wire logic                cor_err_remote_msg,
    input wire logic                remote_err_msg_out,
    input wire logic [2*NUM_VF-1:0] virtual_fn_enable_status,
    input wire logic [3*NUM_PF-1:0] function_power_state,
    input wire logic [1:0]          link_power_state,
    input wire logic                cor_err_out
);
    // address-phase decode; outputs may only move three edges after it
    logic wr_any;
    logic wr_link;
    logic wr_vf;
    logic cause;
    assign wr_any  = hsel && hready && hwrite && (htrans == cpes_pkg::HTRANS_NONSEQ);
    assign wr_link = wr_any && (haddr[7:0] == cpes_pkg::OFS_LINK_PWR);
    assign wr_vf   = wr_any && (haddr[7:0] == cpes_pkg::OFS_VF_STAT);
    assign cause   = (|cor_err_detect) || cor_err_local;

    function automatic logic ok3(input logic [2:0] c);
        return c inside {3'h0, 3'h1, 3'h2, 3'h4};
    endfunction

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_vf_cause: assert property ($changed(virtual_fn_enable_status) |-> $past(wr_vf, 3))
        else $error("vf status moved without a write");
    chk_pf_codes: assert property (ok3(function_power_state[2:0])
        && ok3(function_power_state[5:3]))
        else $error("undefined power code shown");
    chk_link_cause: assert property ($changed(link_power_state) |-> $past(wr_link, 3))
        else $error("link state moved without a write");
    chk_cor_cause: assert property (cor_err_out |-> $past(cause))
        else $error("correctable pulse without a detection");
    chk_cor_single: assert property (cor_err_out && !cause |=> !cor_err_out)
        else $error("correctable pulse longer than one cycle");
    chk_remote_iso: assert property (cor_err_remote_msg && !cause |=> !cor_err_out)
        else $error("remote message reached correctable output");
    chk_remote_fwd: assert property (remote_err_msg_out == $past(cor_err_remote_msg))
        else $error("remote message not forwarded next cycle");
    chk_reset_quiet: assert property (disable iff (1'b0)
        !hresetn |-> !cor_err_out && !hreadyout && link_power_state == 2'h0)
        else $error("outputs active during reset");

    // main scenarios reached
    cover property (cor_err_out ##1 cor_err_out);
    cover property ($changed(link_power_state));
    cover property (remote_err_msg_out);
endmodule

bind cpes_status_outputs cpes_status_outputs_checker #(.NUM_PF(NUM_PF), .NUM_VF(NUM_VF)) chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .cor_err_detect(cor_err_detect),
    .cor_err_local(cor_err_local), .cor_err_remote_msg(cor_err_remote_msg),
    .remote_err_msg_out(remote_err_msg_out), .virtual_fn_enable_status(virtual_fn_enable_status),
    .function_power_state(function_power_state), .link_power_state(link_power_state),
    .cor_err_out(cor_err_out));
`default_nettype wire

//--- test/cpes_status_outputs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cpes_status_outputs_tb;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [1:0]  det;
    logic        loc;
    logic        rmt;
    logic        rmt_out;
    logic [11:0] vfs;
    logic [5:0]  pfp;
    logic [17:0] vfp;
    logic [1:0]  lps;
    logic        cor;
    logic [7:0]  cor_cnt;
    logic [7:0]  msg_cnt;
    logic [31:0] rd;
    int          n_mismatch;
    int          compares;
    int          cycles;

    cpes_status_outputs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cor_err_detect(det),
        .cor_err_local(loc), .cor_err_remote_msg(rmt), .remote_err_msg_out(rmt_out),
        .virtual_fn_enable_status(vfs), .function_power_state(pfp),
        .virtual_fn_power_state(vfp), .link_power_state(lps), .cor_err_out(cor));
    cpes_user_model user_u (.hclk(hclk), .hresetn(hresetn), .cor_err_out(cor),
        .remote_err_msg_out(rmt_out), .cor_cnt_ff(cor_cnt), .msg_cnt_ff(msg_cnt));

    // 40 ns clock; the run needs well under the ceiling
    always #20 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one single-word transfer; address held until hready seen, data taken at second edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= cpes_pkg::HTRANS_NONSEQ;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    task automatic ev(input logic [1:0] d, input logic l, input logic m);
        @(posedge hclk);
        det <= d;
        loc <= l;
        rmt <= m;
    endtask

    task automatic t_regs();
        logic [1:0] lk [4] = '{cpes_pkg::LINK_L0, cpes_pkg::LINK_L0S, cpes_pkg::LINK_L1,
                               cpes_pkg::LINK_L2};
        ahb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b1, cpes_pkg::OFS_VF_STAT, 32'hffff_fa5c);
        step(1);
        chk(vfs, 12'ha5c);
        ahb(1'b1, cpes_pkg::OFS_PF_PWR, {26'h0, cpes_pkg::PWR_D3_HOT, cpes_pkg::PWR_D0_ACTIVE});
        ahb(1'b1, cpes_pkg::OFS_PF_PWR, {26'h0, 3'h7, cpes_pkg::PWR_D1});
        step(1);
        chk(pfp, {cpes_pkg::PWR_D3_HOT, cpes_pkg::PWR_D1});
        ahb(1'b1, cpes_pkg::OFS_VF_PWR, {14'h0, cpes_pkg::PWR_D0_ACTIVE, cpes_pkg::PWR_D1,
            cpes_pkg::PWR_D0_UNINIT, cpes_pkg::PWR_D0_ACTIVE, cpes_pkg::PWR_D1, 3'h4});
        step(1);
        chk(vfp, 18'o120_124);
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, cpes_pkg::OFS_LINK_PWR, 32'(i));
            step(1);
            chk(lps, lk[i]);
        end
    endtask

    task automatic t_cor();
        ahb(1'b1, cpes_pkg::OFS_CTRL, 32'h6);
        ev(2'b01, 1'b0, 1'b0);
        ev(2'b10, 1'b0, 1'b0);
        #1 chk(cor, 1'b1);
        ev(2'b00, 1'b0, 1'b0);
        #1 chk(cor, 1'b1);
        step(1);
        chk(cor, 1'b0);
        ahb(1'b1, cpes_pkg::OFS_CTRL, 32'h2);
        ev(2'b10, 1'b0, 1'b0);
        ev(2'b00, 1'b0, 1'b1);
        ev(2'b00, 1'b0, 1'b0);
        #1 chk({rmt_out, cor}, 2'b10);
        ahb(1'b0, cpes_pkg::OFS_DEV_STAT, 32'h0);
        chk(rd, 32'h3);
        ahb(1'b1, cpes_pkg::OFS_DEV_STAT, 32'h1);
        ahb(1'b0, cpes_pkg::OFS_DEV_STAT, 32'h0);
        chk(rd, 32'h2);
        chk({msg_cnt, cor_cnt}, 16'h0102);
    endtask

    task automatic t_root();
        ahb(1'b1, cpes_pkg::OFS_CTRL, 32'h3);
        step(1);
        chk({pfp, vfp}, 24'h0);
        ev(2'b11, 1'b0, 1'b0);
        ev(2'b00, 1'b1, 1'b0);
        #1 chk(cor, 1'b0);
        ev(2'b00, 1'b0, 1'b0);
        #1 chk(cor, 1'b1);
        ahb(1'b1, cpes_pkg::OFS_CTRL, 32'h1);
        ev(2'b00, 1'b1, 1'b0);
        ev(2'b00, 1'b0, 1'b0);
        #1 chk(cor, 1'b0);
        ahb(1'b1, cpes_pkg::OFS_CTRL, 32'h0);
        step(1);
        chk(pfp, {cpes_pkg::PWR_D3_HOT, cpes_pkg::PWR_D1});
    endtask

    // inputs settle at time zero, reset held four cycles, then a second reset at the end of the run
    initial begin
        {hclk, hresetn, hwrite, loc, rmt} = '0;
        {haddr, hwdata, htrans, det, n_mismatch, compares, cycles} = '0;
        hsel = 1'b1;
        repeat (4) @(posedge hclk);
        chk({hreadyout, hresp, cor, lps, vfs}, 17'h0);
        hresetn <= 1'b1;
        step(1);
        t_regs();
        t_cor();
        t_root();
        @(posedge hclk);
        hresetn <= 1'b0;
        #1 chk({cor, lps, vfs, pfp}, 21'h0);
        step(2);
        stop_test();
    end
endmodule
`default_nettype wire

//--- test/cpes_user_model.sv
`timescale 1ns/1ns
`default_nettype none
module cpes_user_model (
    input wire logic  hclk,
    input wire logic  hresetn,
    input wire logic  cor_err_out,
    input wire logic  remote_err_msg_out,
    output logic [7:0] cor_cnt_ff,
    output logic [7:0] msg_cnt_ff
);
    // user logic tallies each high cycle as one event, so a stretched pulse over-counts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cor_cnt_ff <= 8'h00;
            msg_cnt_ff <= 8'h00;
        end else begin
            cor_cnt_ff <= cor_cnt_ff + {7'h00, cor_err_out};
            msg_cnt_ff <= msg_cnt_ff + {7'h00, remote_err_msg_out};
        end
    end
endmodule
`default_nettype wire
